//--- bench/dslc_ctrl_properties.sv
// port-level checks for the dual serial link status controller
`timescale 1ns/1ps
module dslc_ctrl_properties
  import dslc_pkg::*;
#(
  parameter int LED_HOLD = LED_HOLD_CYC
) (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic [AW-1:0]      paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire dslc_ss_t [NCH-1:0] ssOut,
  input wire dslc_ss_t [NCH-1:0] ssOe,
  input wire logic [1:0]         linkSpeedSel,
  input wire logic [NCH-1:0]     linkTxPin,
  input wire logic               identLed,
  input wire logic [NCH-1:0]     ledGreen,
  input wire logic [NCH-1:0]     ledYellow
);
  logic       wrCtl;
  logic [6:0] ctl;
  logic [6:0] next_ctl;
  // shadow of the global settings, taken from completed writes only
  assign wrCtl = psel && penable && pready && pwrite && paddr == OFS_CTRL;
  always_comb begin
    next_ctl = wrCtl ? pwdata[6:0] : ctl;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl <= 7'h09;
    end else begin
      ctl <= next_ctl;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  AST_APB_WAIT: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access cycle");
  AST_SPEED: assert property (wrCtl |=> ##1 linkSpeedSel == $past(pwdata[3:2], 2))
    else $error("speed code not taken from write");
  AST_SPEED_HOLD: assert property (!wrCtl && !$past(wrCtl) |=> $stable(linkSpeedSel))
    else $error("speed code changed without write");
  AST_OC: assert property (ssOut == '0)
    else $error("subsystem line driven high");
  AST_ALT: assert property (ctl[4] && $past(ctl[4])
    |-> ssOe[0].subsysAnalyseLineN == !ssOe[0].subsysResetLineN)
    else $error("analyse not inverse of reset");
  AST_XBACK: assert property (ctl[5] && $past(ctl[5]) |-> linkTxPin == '0)
    else $error("tx pins active while crossed");
  AST_LED_OFF: assert property (ctl[1:0] == 2'h0 && $past(ctl[1:0]) == 2'h0
    |-> ledGreen == '0 && ledYellow == '0)
    else $error("leds lit in off mode");
  AST_IDENT: assert property (ctl[6] && $past(ctl[6]) |-> identLed)
    else $error("ident led dark while switched on");
endmodule
bind dslc_ctrl dslc_ctrl_properties #(.LED_HOLD(LED_HOLD)) u_props (
  .mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .ssOut, .ssOe,
  .linkSpeedSel, .linkTxPin, .identLed, .ledGreen, .ledYellow
);

//--- bench/dslc_far_model.sv
// remote processor stand-in: returns each link's serial stream after a delay
`timescale 1ns/1ps
module dslc_far_model
  import dslc_pkg::*;
#(
  parameter int LAT = 3
) (
  input  wire logic           mclk,
  input  wire logic [NCH-1:0] linkTxPin,
  output logic      [NCH-1:0] linkRxPin
);
  logic [NCH-1:0] pipe [LAT];
  // receive line has a pull-down, so an idle remote reads low
  initial pipe = '{default: '0};
  always @(posedge mclk) begin
    pipe[0] <= linkTxPin;
    for (int i = 1; i < LAT; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  // each link echoed on its own; a larger LAT models a slow remote
  assign linkRxPin = pipe[LAT-1];
endmodule

//--- bench/testbench.sv
// self-checking bench for the dual serial link status controller
`timescale 1ns/1ps
module testbench
  import dslc_pkg::*;
;
  logic                    mclk = 1'h0;
  logic                    rst = 1'h1;
  logic [AW-1:0]           paddr = '0;
  logic                    psel = 1'h0;
  logic                    penable = 1'h0;
  logic                    pwrite = 1'h0;
  logic [31:0]             pwdata = '0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  dslc_link_ev_t [NCH-1:0] linkEv = '0;
  logic [NCH-1:0]          engTx = '0;
  logic [NCH-1:0]          engRx;
  logic [NCH-1:0]          linkTxPin;
  logic [NCH-1:0]          linkRxPin;
  dslc_ss_t [NCH-1:0]      ssIn;
  dslc_ss_t [NCH-1:0]      ssOut;
  dslc_ss_t [NCH-1:0]      ssOe;
  dslc_ss_t [NCH-1:0]      farN = '1;
  logic [1:0]              linkSpeedSel;
  logic                    cfgBusyPin = 1'h0;
  logic                    identLed;
  logic [NCH-1:0]          ledGreen;
  logic [NCH-1:0]          ledYellow;
  logic [31:0]             rd;
  logic                    perr;
  int                      errors = 0;
  int                      samples_checked = 0;
  int                      cyc = 0;
  // pulled-up lines: low when either end pulls
  assign ssIn = ~ssOe & farN;
  always #10 mclk = ~mclk;
  dslc_ctrl #(.LED_HOLD(8)) i_dut (
    .mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
    .linkEv, .engTx, .engRx, .linkTxPin, .linkRxPin, .ssIn, .ssOut, .ssOe, .linkSpeedSel,
    .cfgBusyPin, .identLed, .ledGreen, .ledYellow
  );
  dslc_far_model #(.LAT(3)) u_far (.mclk, .linkTxPin, .linkRxPin);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // the run should take well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge mclk);
    penable <= 1'h1;
    // no local limit: a slave that never answers runs into the cycle timeout
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'h0, '0);
    chk(n, rd, e);
  endtask
  task automatic ev(input int l, input int b);
    @(posedge mclk);
    linkEv[l][b] <= 1'h1;
    @(posedge mclk);
    linkEv[l][b] <= 1'h0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic t_reset();
    chk("speed", 32'(linkSpeedSel), 32'h2);
    rdc("ctrl", OFS_CTRL, 32'h0000_0009);
    apb(OFS_STS0, 1'h1, 32'h0000_000F);
    rdc("sts0", OFS_STS0, 32'h0);
    apb(8'h1C, 1'h0, '0);
    chk("unmapped", {rd[31:1], perr}, 32'h1);
  endtask
  task automatic t_speed();
    for (int s = 0; s < 4; s++) begin
      apb(OFS_CTRL, 1'h1, 32'(s * 4 + 1));
      wt(2);
      chk("speed", 32'(linkSpeedSel), 32'(s));
    end
  endtask
  task automatic t_leds();
    logic [7:0] tbl;
    tbl = 8'h68;
    @(posedge mclk);
    linkEv[0].rxqFull <= 1'h1;
    for (int m = 0; m < 4; m++) begin
      apb(OFS_CTRL, 1'h1, 32'(8 + m));
      ev(0, 7);
      wt(2);
      chk("leds", 32'({ledGreen[0], ledYellow[0]}), 32'(tbl[2*m+:2]));
    end
    linkEv[0].rxqFull <= 1'h0;
    // one byte keeps the activity led lit for the hold count, then it goes dark
    apb(OFS_CTRL, 1'h1, 32'h0000_0009);
    ev(0, 7);
    wt(9);
    chk("hold", 32'(ledGreen[0]), 32'h1);
    wt(1);
    chk("hold", 32'(ledGreen[0]), 32'h0);
  endtask
  task automatic t_fault();
    apb(OFS_IMASK, 1'h1, 32'h1);
    ev(0, 2);
    rdc("sts0", OFS_STS0, 32'h8);
    chk("yellow", 32'(ledYellow[0]), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    apb(OFS_ISTAT, 1'h1, 32'h1);
    wt(2);
    chk("irq", 32'(irq), 32'h0);
    ev(1, 3);
    ev(1, 3);
    rdc("sts1", OFS_STS1, 32'h8);
    chk("irq", 32'(irq), 32'h0);
    apb(OFS_CHCTL0, 1'h1, 32'h10);
    rdc("sts0", OFS_STS0, 32'h0);
    rdc("sts1", OFS_STS1, 32'h8);
    apb(OFS_CHCTL1, 1'h1, 32'h10);
    ev(0, 5);
    ev(0, 2);
    ev(1, 3);
    ev(1, 4);
    ev(1, 3);
    rdc("sts0", OFS_STS0, 32'h0);
    rdc("sts1", OFS_STS1, 32'h0);
  endtask
  task automatic t_pins();
    apb(OFS_CHCTL0, 1'h1, 32'h1);
    wt(2);
    chk("oe", 32'(ssOe[0]), 32'h4);
    apb(OFS_CTRL, 1'h1, 32'h19);
    apb(OFS_CHCTL0, 1'h1, 32'h0);
    wt(5);
    chk("oe", 32'(ssOe[0]), 32'h2);
    rdc("sts0", OFS_STS0, 32'h2);
    apb(OFS_CTRL, 1'h1, 32'h9);
    apb(OFS_IMASK, 1'h1, 32'h0);
    farN[1].subsysErrorLineN <= 1'h0;
    wt(6);
    rdc("sts1", OFS_STS1, 32'h4);
    rdc("istat", OFS_ISTAT, 32'hA);
    chk("irq", 32'(irq), 32'h0);
    apb(OFS_IMASK, 1'h1, 32'h8);
    wt(2);
    chk("irq", 32'(irq), 32'h1);
    apb(OFS_ISTAT, 1'h1, 32'hF);
    wt(2);
    chk("irq", 32'(irq), 32'h0);
    farN <= '1;
  endtask
  task automatic t_misc();
    cfgBusyPin <= 1'h1;
    wt(5);
    chk("ident", 32'(identLed), 32'h1);
    cfgBusyPin <= 1'h0;
    apb(OFS_CTRL, 1'h1, 32'h49);
    wt(2);
    chk("ident", 32'(identLed), 32'h1);
    apb(OFS_CTRL, 1'h1, 32'h9);
    engTx <= 2'h2;
    wt(10);
    chk("echo", 32'(engRx), 32'h2);
    apb(OFS_CHCTL0, 1'h1, 32'h8);
    engTx <= 2'h1;
    wt(3);
    chk("loop", 32'({engRx[0], linkTxPin[0]}), 32'h2);
    apb(OFS_CTRL, 1'h1, 32'h29);
    wt(3);
    chk("cross", 32'({engRx, linkTxPin}), 32'h8);
    apb(OFS_CTRL, 1'h1, 32'h35);
    rst <= 1'h1;
    wt(3);
    rst <= 1'h0;
    rdc("ctrl", OFS_CTRL, 32'h9);
    rdc("chctl0", OFS_CHCTL0, 32'h0);
    chk("speed", 32'(linkSpeedSel), 32'h2);
  endtask
  initial begin
    wt(3);
    rst <= 1'h0;
    t_reset();
    t_speed();
    t_leds();
    t_fault();
    t_pins();
    t_misc();
    stop_test();
  end
endmodule

//--- core/dslc_ctrl.sv
// top of the dual serial link status controller with apb register access
`timescale 1ns/1ps
module dslc_ctrl
  import dslc_pkg::*;
#(
  parameter int LED_HOLD = LED_HOLD_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [AW-1:0]          paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  input  wire dslc_link_ev_t [NCH-1:0] linkEv,
  input  wire logic [NCH-1:0]         engTx,
  output logic      [NCH-1:0]         engRx,
  output logic      [NCH-1:0]         linkTxPin,
  input  wire logic [NCH-1:0]         linkRxPin,
  input  wire dslc_ss_t [NCH-1:0]     ssIn,
  output dslc_ss_t  [NCH-1:0]         ssOut,
  output dslc_ss_t  [NCH-1:0]         ssOe,
  output logic      [1:0]             linkSpeedSel,
  input  wire logic                   cfgBusyPin,
  output logic                        identLed,
  output logic      [NCH-1:0]         ledGreen,
  output logic      [NCH-1:0]         ledYellow
);
  localparam int CW = $clog2(LED_HOLD + 1);
  if (LED_HOLD < 1) begin : g_bad_hold
    $error("LED_HOLD must be at least one cycle");
  end

  // rst is the whole-unit reset: button and power cycle end up here alike
  // configuration state
  dslc_ledm_t           ledMode, next_ledMode;
  logic [1:0]           speed, next_speed;
  logic                 pinAlt, next_pinAlt;
  logic                 xback, next_xback;
  logic                 identOn, next_identOn;
  logic [NCH-1:0][3:0]  chCtl, next_chCtl;
  logic [NCH-1:0]       initCmd;
  logic [IRQ_W-1:0]     iStat, next_iStat;
  logic [IRQ_W-1:0]     iMask, next_iMask;
  logic [IRQ_W-1:0]     iEvent;

  // synchronisers for pins
  dslc_ss_t [NCH-1:0]   ssMeta, ssSync;
  logic [NCH-1:0]       rxMeta, rxSync;
  logic                 cfgMeta, cfgSync;
  logic [NCH-1:0]       errPrev;

  // link fault tracking
  logic [NCH-1:0]       fault;
  logic [NCH-1:0]       faultSet;

  // apb
  logic                 wrEn;
  logic                 setup;
  logic                 hit;
  logic [31:0]          rdMux;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;

  assign setup = psel && !penable;
  assign wrEn  = psel && penable && pready && pwrite;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ssMeta  <= '1;
      ssSync  <= '1;
      rxMeta  <= '0;
      rxSync  <= '0;
      cfgMeta <= 1'b0;
      cfgSync <= 1'b0;
    end else begin
      ssMeta  <= ssIn;
      ssSync  <= ssMeta;
      rxMeta  <= linkRxPin;
      rxSync  <= rxMeta;
      cfgMeta <= cfgBusyPin;
      cfgSync <= cfgMeta;
    end
  end

  // register read mux, upper status bits read zero
  always_comb begin
    hit   = 1'b1;
    rdMux = '0;
    unique case (paddr)
      OFS_CTRL: begin
        rdMux[CTL_LEDM +: 2] = ledMode;
        rdMux[CTL_SPD +: 2]  = speed;
        rdMux[CTL_ALT]       = pinAlt;
        rdMux[CTL_XBACK]     = xback;
        rdMux[CTL_IDENT]     = identOn;
      end
      OFS_CHCTL0: rdMux[3:0] = chCtl[0];
      OFS_CHCTL1: rdMux[3:0] = chCtl[1];
      OFS_STS0, OFS_STS1: begin
        // per-link status: line bits read back from the lines themselves, fault bit from the fault tracking
        rdMux[STS_RST]   = !ssSync[paddr == OFS_STS1].subsysResetLineN;
        rdMux[STS_ANA]   = !ssSync[paddr == OFS_STS1].subsysAnalyseLineN;
        rdMux[STS_ERR]   = !ssSync[paddr == OFS_STS1].subsysErrorLineN;
        rdMux[STS_FAULT] = fault[paddr == OFS_STS1];
      end
      OFS_ISTAT: rdMux[IRQ_W-1:0] = iStat;
      OFS_IMASK: rdMux[IRQ_W-1:0] = iMask;
      default:   hit = 1'b0;
    endcase
  end

  // no wait state: answer registered in the setup cycle
  always_comb begin
    next_pready  = setup;
    next_prdata  = setup ? (pwrite ? 32'h0000_0000 : rdMux) : prdata;
    next_pslverr = setup && !hit;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // settings hold until rewritten or reset
  always_comb begin
    next_ledMode = ledMode;
    next_speed   = speed;
    next_pinAlt  = pinAlt;
    next_xback   = xback;
    next_identOn = identOn;
    next_chCtl   = chCtl;
    next_iMask   = iMask;
    initCmd      = '0;
    if (wrEn) begin
      unique case (paddr)
        OFS_CTRL: begin
          next_ledMode = dslc_ledm_t'(pwdata[CTL_LEDM +: 2]);
          next_speed   = pwdata[CTL_SPD +: 2];
          next_pinAlt  = pwdata[CTL_ALT];
          next_xback   = pwdata[CTL_XBACK];
          next_identOn = pwdata[CTL_IDENT];
        end
        OFS_CHCTL0: begin
          next_chCtl[0] = pwdata[3:0];
          initCmd[0]    = pwdata[CH_INIT];
        end
        OFS_CHCTL1: begin
          next_chCtl[1] = pwdata[3:0];
          initCmd[1]    = pwdata[CH_INIT];
        end
        OFS_IMASK: next_iMask = pwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ledMode <= LEDM_RST;
      speed   <= SPD_RST;
      pinAlt  <= 1'b0;
      xback   <= 1'b0;
      identOn <= 1'b0;
      chCtl   <= '0;
      iMask   <= '0;
    end else begin
      ledMode <= next_ledMode;
      speed   <= next_speed;
      pinAlt  <= next_pinAlt;
      xback   <= next_xback;
      identOn <= next_identOn;
      chCtl   <= next_chCtl;
      iMask   <= next_iMask;
    end
  end

  // sticky interrupt status, write one to clear; a new event wins over the clear
  always_comb begin
    next_iStat = iStat;
    if (wrEn && paddr == OFS_ISTAT) begin
      next_iStat = iStat & ~pwdata[IRQ_W-1:0];
    end
    next_iStat = next_iStat | iEvent;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      iStat <= '0;
      irq   <= 1'b0;
    end else begin
      iStat <= next_iStat;
      irq   <= |(next_iStat & iMask);
    end
  end

  // ident led: lit while configuration is busy or on request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      identLed     <= 1'b0;
      linkSpeedSel <= SPD_RST;
    end else begin
      identLed     <= cfgSync || identOn;
      linkSpeedSel <= speed;
    end
  end

  // channel_zero and channel_one are built alike and run independently, except that crossback feeds each receive from the other's transmit
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic          ackWait, next_ackWait;
    logic          ackOwed, next_ackOwed;
    logic          next_fault;
    logic [CW-1:0] txCnt, next_txCnt;
    logic [CW-1:0] rxCnt, next_rxCnt;
    logic          next_green, next_yellow;
    logic          rxSrc;
    dslc_ss_t      next_oe;
    logic          errAct;

    // fault detection on illegal receive sequences
    always_comb begin
      faultSet[i]  = 1'b0;
      next_ackWait = ackWait;
      next_ackOwed = ackOwed;
      if (linkEv[i].rxAck) begin
        faultSet[i]  = !ackWait;
        next_ackWait = 1'b0;
      end
      if (linkEv[i].txData) begin
        next_ackWait = 1'b1;
      end
      if (linkEv[i].txAck) begin
        next_ackOwed = 1'b0;
      end
      if (linkEv[i].rxData) begin
        faultSet[i]  = faultSet[i] || ackOwed;
        next_ackOwed = 1'b1;
      end
      // init clears only this link; a fault in the same cycle still wins
      next_fault = faultSet[i] || (fault[i] && !initCmd[i]);
      if (initCmd[i]) begin
        next_ackWait = 1'b0;
        next_ackOwed = 1'b0;
      end
    end

    // activity stretch reloads on every byte, never looks at the data
    always_comb begin
      next_txCnt = (txCnt != '0) ? txCnt - 1'b1 : txCnt;
      next_rxCnt = (rxCnt != '0) ? rxCnt - 1'b1 : rxCnt;
      if (linkEv[i].txByte) begin
        next_txCnt = CW'(LED_HOLD);
      end
      if (linkEv[i].rxByte) begin
        next_rxCnt = CW'(LED_HOLD);
      end
    end

    assign errAct = !ssSync[i].subsysErrorLineN;

    // led selection per mode
    always_comb begin
      unique case (ledMode)
        LED_OFF: begin
          next_green  = 1'b0;
          next_yellow = 1'b0;
        end
        LED_STD: begin
          next_green  = (txCnt != '0) || (rxCnt != '0);
          next_yellow = errAct || fault[i];
        end
        LED_DATA: begin
          next_green  = txCnt != '0;
          next_yellow = rxCnt != '0;
        end
        LED_DBG: begin
          next_green  = linkEv[i].txqEmpty;
          next_yellow = linkEv[i].rxqFull;
        end
      endcase
    end

    // open-collector drive: enable pulls the line low
    always_comb begin
      next_oe.subsysResetLineN   = chCtl[i][CH_RST];
      next_oe.subsysAnalyseLineN = pinAlt ? !chCtl[i][CH_RST] : chCtl[i][CH_ANA];
      next_oe.subsysErrorLineN   = chCtl[i][CH_ERR];
    end

    // crossback takes priority over loopback; the pin stays idle while diverted
    assign rxSrc = xback ? engTx[NCH-1-i] : (chCtl[i][CH_LOOP] ? engTx[i] : rxSync[i]);

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ackWait      <= 1'b0;
        ackOwed      <= 1'b0;
        fault[i]     <= 1'b0;
        txCnt        <= '0;
        rxCnt        <= '0;
        ledGreen[i]  <= 1'b0;
        ledYellow[i] <= 1'b0;
        ssOe[i]      <= '0;
        ssOut[i]     <= '0;
        engRx[i]     <= 1'b0;
        linkTxPin[i] <= 1'b0;
        errPrev[i]   <= 1'b0;
      end else begin
        ackWait      <= next_ackWait;
        ackOwed      <= next_ackOwed;
        fault[i]     <= next_fault;
        txCnt        <= next_txCnt;
        rxCnt        <= next_rxCnt;
        ledGreen[i]  <= next_green;
        ledYellow[i] <= next_yellow;
        ssOe[i]      <= next_oe;
        ssOut[i]     <= '0;
        engRx[i]     <= rxSrc;
        linkTxPin[i] <= (xback || chCtl[i][CH_LOOP]) ? 1'b0 : engTx[i];
        errPrev[i]   <= errAct;
      end
    end

    assign iEvent[IRQ_FAULT + i] = faultSet[i] && !fault[i];
    assign iEvent[IRQ_ERRIN + i] = errAct && !errPrev[i];
  end

endmodule

//--- include/dslc_pkg.sv
// constants and types for the dual serial link status controller
package dslc_pkg;
  localparam int NCH = 2;
  localparam int AW  = 8;
  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_CHCTL0 = 8'h04;
  localparam logic [AW-1:0] OFS_CHCTL1 = 8'h08;
  localparam logic [AW-1:0] OFS_STS0   = 8'h0C;
  localparam logic [AW-1:0] OFS_STS1   = 8'h10;
  localparam logic [AW-1:0] OFS_ISTAT  = 8'h14;
  localparam logic [AW-1:0] OFS_IMASK  = 8'h18;
  // global control fields
  localparam int CTL_LEDM  = 0;
  localparam int CTL_SPD   = 2;
  localparam int CTL_ALT   = 4;
  localparam int CTL_XBACK = 5;
  localparam int CTL_IDENT = 6;
  // per-link control fields
  localparam int CH_RST  = 0;
  localparam int CH_ANA  = 1;
  localparam int CH_ERR  = 2;
  localparam int CH_LOOP = 3;
  localparam int CH_INIT = 4;
  // per-link status byte
  localparam int STS_RST   = 0;
  localparam int STS_ANA   = 1;
  localparam int STS_ERR   = 2;
  localparam int STS_FAULT = 3;
  // interrupt bits: fault entry per link, then error line assertion per link
  localparam int IRQ_W     = 4;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_ERRIN = 2;
  // speed codes: 0 = 5 MHz, 1 = 10 MHz, 2 = 20 MHz, 3 = 40 MHz (test only)
  localparam logic [1:0] SPD_RST = 2'h2;
  typedef enum logic [1:0] {
    LED_OFF  = 2'b00,
    LED_STD  = 2'b01,
    LED_DATA = 2'b10,
    LED_DBG  = 2'b11
  } dslc_ledm_t;
  localparam dslc_ledm_t LEDM_RST = LED_STD;
  // activity stretch so short transfers stay visible
  localparam int CLK_NS       = 20;
  localparam int LED_HOLD_NS  = 20_000_000;
  localparam int LED_HOLD_CYC = LED_HOLD_NS / CLK_NS;
  // per-link events from the packet engine, same clock
  typedef struct packed {
    logic txByte;
    logic rxByte;
    logic txData;
    logic txAck;
    logic rxData;
    logic rxAck;
    logic txqEmpty;
    logic rxqFull;
  } dslc_link_ev_t;
  // subsystem open-collector lines, low means asserted
  typedef struct packed {
    logic subsysResetLineN;
    logic subsysAnalyseLineN;
    logic subsysErrorLineN;
  } dslc_ss_t;
endpackage
